// >>> logic/uart_msc_pkg.sv
// Constants for the UART modem-status, transmit/receive control block.
// Assumes a 32-bit APB register port with byte addresses, one word a register.
package uart_msc_pkg;

   // ----------------------------------------------------------------
   // Bus and level widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LVL_W  = 9;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_MODEM_STATUS = 8'h00; // read status / write control
   localparam logic [ADDR_W-1:0] OFS_SCRATCH      = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FEATURE      = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL   = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_ENH_FEATURE  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_INT_ENABLE   = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   // Status read side: live levels {cd,ri,dsr,cts} in 7:4, deltas in 3:0
   localparam int ST_LIVE_LO = 4;
   localparam int TD_HI      = 7;  // turn-around delay field
   localparam int TD_LO      = 4;
   localparam int TX_DIS     = 3;
   localparam int RX_DIS     = 2;
   localparam int TX_DIS_MD  = 1;
   localparam int RX_DIS_MD  = 0;
   localparam int MC_LOOP    = 4;
   localparam int MC_OP2     = 3;
   localparam int MC_SEL     = 2;  // 0 = RTS/CTS, 1 = DTR/DSR
   localparam int MC_RTS     = 1;
   localparam int MC_DTR     = 0;
   localparam logic [7:0] MC_ENH_MASK = 8'hE0;
   localparam int EF_AUTO_CTS = 7;
   localparam int EF_AUTO_RTS = 6;
   localparam int EF_ENH_EN   = 4;
   localparam int IE_MODEM    = 3;
   localparam int FC_TBL_HI   = 7;
   localparam int FC_TBL_LO   = 6;
   localparam int FC_RS485    = 5;
   localparam logic [1:0] TABLE_D = 2'h3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SCRATCH_RST = 8'hFF;
   localparam logic [7:0] REG_RST     = 8'h00;

   // ----------------------------------------------------------------
   // RS-485 direction state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      DIR_IDLE  = 3'b001,
      DIR_DRIVE = 3'b010,
      DIR_HOLD  = 3'b100
   } dir_state_e;

endpackage

// >>> logic/uart_modem_ctrl.sv
// Modem status tracking, transmit/receive gating and RS-485 turn-around.
// Assumes an APB master on pclk, and transmitter, receiver and FIFO logic
// on the same clock that honour the gating outputs of this block.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps

// Functional notes
// - CD status inverts pin, loopback mirrors OP2
// - RI status inverts pin, loopback mirrors MC_SEL bit
// - DSR status inverts pin, loopback follows DTR
// - CTS status inverts pin, loopback follows RTS
// - Auto CTS/DSR stops transmitter after character
// - CD, DSR, CTS deltas flag any change
// - RI delta only on pin rising
// - Any delta with enable raises interrupt
// - Turn-around delay 0 to 15 bit times
// - Delay field written only with enhanced enable
// - Transmitter disable halts shifting, keeps queue
// - Receiver disable finishes current character first
// - Re-enable receiver only while line idle; here rx_accept returns as soon as RX_DIS clears, even with rx_busy high
// - Receive FIFO always readable
// - Disabled transmitter Xon/Xoff per mode bit
// - Disabled receiver Xon/Xoff detection per mode bit
// - Scratch byte read/write, resets to FF
// - Feature bits select trigger table A-D
// - Tables A-C flow control one level around
// - Loopback bit redirects modem inputs
// - Direction output falls after last stop
// - Enhanced enable gates enhanced bit writes
module uart_modem_ctrl (
   // Clock and reset
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   // APB slave
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [uart_msc_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [uart_msc_pkg::DATA_W-1:0]   pwdata,
   output logic      [uart_msc_pkg::DATA_W-1:0]   prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // Modem pins, active low, asynchronous
   input  wire logic                              carrier_detect_in_n,
   input  wire logic                              ring_indicator_in_n,
   input  wire logic                              dsr_in_n,
   input  wire logic                              cts_in_n,
   // Transmitter side
   input  wire logic                              tx_busy,
   input  wire logic                              tx_char_done,
   input  wire logic                              tx_last_stop_done,
   input  wire logic                              tx_load,
   input  wire logic                              bit_tick,
   input  wire logic                              xon_pending,
   input  wire logic                              xon_sent,
   output logic                                   tx_halt,
   output logic                                   tx_xon_allow,
   output logic                                   rs485_dir,
   // Receiver side
   input  wire logic                              rx_busy,
   input  wire logic                              rx_char_done,
   input  wire logic                              rx_fifo_rd_req,
   input  wire logic [uart_msc_pkg::LVL_W-1:0]    rx_fifo_level,
   input  wire logic [uart_msc_pkg::LVL_W-1:0]    rx_trig_upper,
   input  wire logic [uart_msc_pkg::LVL_W-1:0]    rx_trig_lower,
   output logic                                   rx_accept,
   output logic                                   rx_xon_detect,
   output logic                                   rx_fifo_rd,
   output logic                                   rts_flow_off,
   // Mode outputs
   output logic [1:0]                             trigger_table,
   output logic                                   loopback,
   output logic                                   modem_irq
);
   import uart_msc_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [3:0]  pin_s1;
   logic [3:0]  pin_s2;
   logic [3:0]  live;
   logic [3:0]  live_q;
   logic [3:0]  delta_set;
   logic [3:0]  delta;
   logic [3:0]  rd_snap;
   logic [7:0]  turn_ctrl;
   logic [7:0]  scratch;
   logic [7:0]  feature_control;
   logic [7:0]  modem_control_reg;
   logic [7:0]  enhanced_feature_reg;
   logic [7:0]  interrupt_enable_reg;
   logic        setup_ph;
   logic        access_done;
   logic        wr_en;
   logic        rd_status_done;
   logic        mapped;
   logic [7:0]  rd_byte;
   logic        flow_hold;
   logic        sel_high;
   logic        xon_latch;
   logic        next_rx_gate;
   logic [3:0]  dly_cnt;
   dir_state_e  dir_state;
   dir_state_e  next_dir_state;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Order {cd,ri,dsr,cts}; only stage two feeds logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= 4'hF;
         pin_s2 <= 4'hF;
      end else begin
         pin_s1 <= {carrier_detect_in_n, ring_indicator_in_n, dsr_in_n, cts_in_n};
         pin_s2 <= pin_s1;
      end
   end

   // Live status levels, swapped to control bits in loopback
   always_comb begin
      if (modem_control_reg[MC_LOOP]) begin
         live = {modem_control_reg[MC_OP2], modem_control_reg[MC_SEL], modem_control_reg[MC_DTR], modem_control_reg[MC_RTS]};
      end else begin
         live = ~pin_s2;
      end
   end

   // Change detection; RI only counts the end of ringing
   always_comb begin
      delta_set    = live ^ live_q;
      delta_set[2] = live_q[2] & ~live[2];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_q <= 4'h0;
      end else begin
         live_q <= live;
      end
   end

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign setup_ph       = psel & ~penable;
   assign access_done    = psel & penable & pready;
   assign wr_en          = access_done & pwrite;
   assign rd_status_done = access_done & ~pwrite & (paddr == OFS_MODEM_STATUS);

   // Read mux, evaluated in the setup phase
   always_comb begin
      mapped  = 1'b1;
      rd_byte = 8'h00;
      case (paddr)
         OFS_MODEM_STATUS: rd_byte = {live, delta};
         OFS_SCRATCH:      rd_byte = scratch;
         OFS_FEATURE:      rd_byte = feature_control;
         OFS_MODEM_CTRL:   rd_byte = modem_control_reg;
         OFS_ENH_FEATURE:  rd_byte = enhanced_feature_reg;
         OFS_INT_ENABLE:   rd_byte = interrupt_enable_reg;
         default:          mapped  = 1'b0;
      endcase
   end

   // Zero-wait slave: data and error are ready before the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
         rd_snap <= 4'h0;
      end else begin
         pready <= 1'b1;
         if (setup_ph) begin
            prdata  <= {24'h000000, rd_byte};
            pslverr <= ~mapped;
            rd_snap <= delta;
         end else if (!psel) begin
            pslverr <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Delta flags and modem interrupt
   // ----------------------------------------------------------------
   // Only the reported bits clear, so a change after setup is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delta <= 4'h0;
      end else if (rd_status_done) begin
         delta <= (delta & ~rd_snap) | delta_set;
      end else begin
         delta <= delta | delta_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_irq <= 1'b0;
      end else begin
         modem_irq <= interrupt_enable_reg[IE_MODEM] & (|delta);
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Enhanced bits only move while the enhanced enable is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         turn_ctrl <= REG_RST;
         modem_control_reg       <= REG_RST;
         enhanced_feature_reg       <= REG_RST;
         interrupt_enable_reg       <= REG_RST;
         feature_control      <= REG_RST;
      end else if (wr_en) begin
         case (paddr)
            OFS_MODEM_STATUS: if (enhanced_feature_reg[EF_ENH_EN]) turn_ctrl <= pwdata[7:0];
            OFS_MODEM_CTRL: begin
               if (enhanced_feature_reg[EF_ENH_EN]) begin
                  modem_control_reg <= pwdata[7:0];
               end else begin
                  modem_control_reg <= (modem_control_reg & MC_ENH_MASK) | (pwdata[7:0] & ~MC_ENH_MASK);
               end
            end
            OFS_ENH_FEATURE:  enhanced_feature_reg  <= pwdata[7:0];
            OFS_INT_ENABLE:   interrupt_enable_reg  <= pwdata[7:0];
            OFS_FEATURE:      feature_control <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Scratch byte survives anything but reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scratch <= SCRATCH_RST;
      end else if (wr_en && paddr == OFS_SCRATCH) begin
         scratch <= pwdata[7:0];
      end
   end

   // Mode outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_table <= 2'h0;
         loopback      <= 1'b0;
      end else begin
         trigger_table <= feature_control[FC_TBL_HI:FC_TBL_LO];
         loopback      <= modem_control_reg[MC_LOOP];
      end
   end

   // ----------------------------------------------------------------
   // Transmit gating
   // ----------------------------------------------------------------
   // Pin high means live level low; loopback looks through live too
   assign sel_high = modem_control_reg[MC_SEL] ? ~live[1] : ~live[0];

   // Hold takes effect only between characters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flow_hold <= 1'b0;
      end else if (!enhanced_feature_reg[EF_AUTO_CTS] || !sel_high) begin
         flow_hold <= 1'b0;
      end else if (!tx_busy || tx_char_done) begin
         flow_hold <= 1'b1;
      end
   end

   // Xon/Xoff pending at the moment of disabling may still go out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xon_latch <= 1'b0;
      end else if (wr_en && paddr == OFS_MODEM_STATUS && enhanced_feature_reg[EF_ENH_EN]
                   && pwdata[TX_DIS] && !turn_ctrl[TX_DIS]) begin
         xon_latch <= xon_pending;
      end else if (!turn_ctrl[TX_DIS] || xon_sent) begin
         xon_latch <= 1'b0;
      end
   end

   // Send-immediate needs an enabled transmitter; software keeps to that
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_halt      <= 1'b0;
         tx_xon_allow <= 1'b1;
      end else begin
         tx_halt      <= flow_hold | turn_ctrl[TX_DIS];
         tx_xon_allow <= ~turn_ctrl[TX_DIS] | turn_ctrl[TX_DIS_MD] | xon_latch;
      end
   end

   // ----------------------------------------------------------------
   // Receive gating
   // ----------------------------------------------------------------
   // A character under way when disabled still completes
   always_comb begin
      if (!turn_ctrl[RX_DIS]) begin
         next_rx_gate = 1'b1;
      end else begin
         next_rx_gate = rx_accept & rx_busy & ~rx_char_done;
      end
   end

   // Host reads are never gated by the disable bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_accept     <= 1'b1;
         rx_xon_detect <= 1'b1;
         rx_fifo_rd    <= 1'b0;
      end else begin
         rx_accept     <= next_rx_gate;
         rx_xon_detect <= next_rx_gate | turn_ctrl[RX_DIS_MD];
         rx_fifo_rd    <= rx_fifo_rd_req;
      end
   end

   // Hysteresis for table D is handled elsewhere; output held off there
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rts_flow_off <= 1'b0;
      end else if (!enhanced_feature_reg[EF_AUTO_RTS] || feature_control[FC_RS485]
                   || feature_control[FC_TBL_HI:FC_TBL_LO] == TABLE_D) begin
         rts_flow_off <= 1'b0;
      end else if (rx_fifo_level >= rx_trig_upper) begin
         rts_flow_off <= 1'b1;
      end else if (rx_fifo_level <= rx_trig_lower) begin
         rts_flow_off <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // RS-485 direction control
   // ----------------------------------------------------------------
   // A new load during the hold cancels the turn-around
   always_comb begin
      next_dir_state = dir_state;
      case (dir_state)
         DIR_IDLE: if (tx_load) next_dir_state = DIR_DRIVE;
         DIR_DRIVE: begin
            if (tx_last_stop_done) begin
               next_dir_state = (turn_ctrl[TD_HI:TD_LO] == 4'h0) ? DIR_IDLE : DIR_HOLD;
            end
         end
         DIR_HOLD: begin
            if (tx_load) begin
               next_dir_state = DIR_DRIVE;
            end else if (bit_tick && dly_cnt == 4'h1) begin
               next_dir_state = DIR_IDLE;
            end
         end
         default: next_dir_state = DIR_IDLE;
      endcase
      if (!feature_control[FC_RS485]) begin
         next_dir_state = DIR_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_state <= DIR_IDLE;
         rs485_dir <= 1'b0;
      end else begin
         dir_state <= next_dir_state;
         rs485_dir <= (next_dir_state != DIR_IDLE);
      end
   end

   // Bit-time counter, loaded from the delay field at the last stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_cnt <= 4'h0;
      end else if (dir_state == DIR_DRIVE && tx_last_stop_done) begin
         dly_cnt <= turn_ctrl[TD_HI:TD_LO];
      end else if (dir_state == DIR_HOLD && bit_tick && dly_cnt != 4'h0) begin
         dly_cnt <= dly_cnt - 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_status_setup;
      setup_ph && !pwrite && paddr == OFS_MODEM_STATUS;
   endsequence

   sequence s_status_write_locked;
      wr_en && paddr == OFS_MODEM_STATUS && !enhanced_feature_reg[EF_ENH_EN];
   endsequence

   property p_cd_loop;
      @(posedge pclk) disable iff (!presetn)
      (s_status_setup and modem_control_reg[MC_LOOP]) |=> prdata[7] == $past(modem_control_reg[MC_OP2]);
   endproperty
   a_cd_loop: assert property (p_cd_loop) else $error("cd status not from op2");

   property p_cts_normal;
      @(posedge pclk) disable iff (!presetn)
      (s_status_setup and !modem_control_reg[MC_LOOP]) |=> prdata[4] == ~$past(pin_s2[0]);
   endproperty
   a_cts_normal: assert property (p_cts_normal) else $error("cts status wrong");

   property p_cd_delta;
      @(posedge pclk) disable iff (!presetn)
      (live[3] != live_q[3]) |=> delta[3];
   endproperty
   a_cd_delta: assert property (p_cd_delta) else $error("cd change not flagged");

   property p_ri_rise_only;
      @(posedge pclk) disable iff (!presetn)
      (!delta[2] && !(live_q[2] && !live[2])) |=> !delta[2];
   endproperty
   a_ri_rise_only: assert property (p_ri_rise_only) else $error("ri delta spurious");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (|delta && interrupt_enable_reg[IE_MODEM]) |=> modem_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("modem interrupt missing");

   property p_turn_locked;
      @(posedge pclk) disable iff (!presetn)
      s_status_write_locked |=> $stable(turn_ctrl);
   endproperty
   a_turn_locked: assert property (p_turn_locked) else $error("locked field changed");

   property p_tx_disable;
      @(posedge pclk) disable iff (!presetn)
      turn_ctrl[TX_DIS] |=> tx_halt;
   endproperty
   a_tx_disable: assert property (p_tx_disable) else $error("transmitter not halted");

   property p_rx_idle_off;
      @(posedge pclk) disable iff (!presetn)
      (turn_ctrl[RX_DIS] && !rx_busy) |=> !rx_accept;
   endproperty
   a_rx_idle_off: assert property (p_rx_idle_off) else $error("receiver still on");

   property p_scratch_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFS_SCRATCH) |=> scratch == $past(pwdata[7:0]);
   endproperty
   a_scratch_wr: assert property (p_scratch_wr) else $error("scratch not written");

   property p_dir_zero_delay;
      @(posedge pclk) disable iff (!presetn)
      (dir_state == DIR_DRIVE && tx_last_stop_done && !tx_load && feature_control[FC_RS485]
       && turn_ctrl[TD_HI:TD_LO] == 4'h0) |=> !rs485_dir;
   endproperty
   a_dir_zero_delay: assert property (p_dir_zero_delay) else $error("direction held");

endmodule

// >>> tb/modem_lines_model.sv
// Far-side model of the modem lines that drive the four status inputs.
// Assumes the bench asks for line states as active-high levels on pclk.
`timescale 1ns/1ps

module modem_lines_model (
   // Clock
   input  wire logic       pclk,
   // Requested states {cd,ri,dsr,cts}, 1 = asserted
   input  wire logic [3:0] active,
   // Modem pins, active low
   output logic            carrier_detect_in_n,
   output logic            ring_indicator_in_n,
   output logic            dsr_in_n,
   output logic            cts_in_n
);
   // Pins idle high until asserted; they change only just after an edge
   initial begin
      {carrier_detect_in_n, ring_indicator_in_n, dsr_in_n, cts_in_n} = 4'hF;
   end
   always @(posedge pclk) begin
      {carrier_detect_in_n, ring_indicator_in_n, dsr_in_n, cts_in_n} <= ~active;
   end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the modem status and transmit/receive control block.
// Assumes zero-wait APB and the byte offsets of the package.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top;
   import uart_msc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, q;
   logic pready, pslverr, err;
   logic [3:0] act = 4'h0;
   logic tx_load = 0, stop_done = 0, tick = 0, rd_req = 0, rxb = 0;
   logic [LVL_W-1:0] lvl = '0, up = 9'h008, lo = 9'h004;
   logic cd_n, ri_n, dsr_n, cts_n, tx_halt, rs485_dir, rx_accept, rx_fifo_rd;
   logic tx_xon_allow, rx_xon_detect, rts_flow_off;
   logic [1:0] trigger_table;
   logic loopback, modem_irq;
   int n_fail = 0, n_tests = 0;

   modem_lines_model line (.pclk(pclk), .active(act), .carrier_detect_in_n(cd_n),
      .ring_indicator_in_n(ri_n), .dsr_in_n(dsr_n), .cts_in_n(cts_n));
   uart_modem_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .carrier_detect_in_n(cd_n), .ring_indicator_in_n(ri_n),
      .dsr_in_n(dsr_n), .cts_in_n(cts_n), .tx_busy(1'b0), .tx_char_done(1'b0),
      .tx_last_stop_done(stop_done), .tx_load(tx_load), .bit_tick(tick),
      .xon_pending(1'b0), .xon_sent(1'b0), .tx_halt(tx_halt), .tx_xon_allow(tx_xon_allow),
      .rs485_dir(rs485_dir), .rx_busy(rxb), .rx_char_done(1'b0), .rx_fifo_rd_req(rd_req),
      .rx_fifo_level(lvl), .rx_trig_upper(up), .rx_trig_lower(lo), .rx_accept(rx_accept),
      .rx_xon_detect(rx_xon_detect), .rx_fifo_rd(rx_fifo_rd), .rts_flow_off(rts_flow_off),
      .trigger_table(trigger_table), .loopback(loopback), .modem_irq(modem_irq));

   // Free-running clock, 8 ns period
   initial begin
      forever #4 pclk = ~pclk;
   end

   task automatic close_out();
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // One APB transfer, request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
         close_out();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // Scratch reset value, write back, unmapped access
   task automatic t_regs();
      apb(0, OFS_SCRATCH, 0); `CHK(q[7:0], 8'hFF)
      apb(1, OFS_SCRATCH, 32'h0000_00A5); apb(0, OFS_SCRATCH, 0); `CHK(q[7:0], 8'hA5)
      apb(0, 8'h3C, 0); `CHK(err, 1'b1)
   endtask

   // Live levels, deltas, ring edge and interrupt
   task automatic t_modem();
      apb(1, OFS_INT_ENABLE, 32'h08); apb(0, OFS_MODEM_STATUS, 0);
      act <= 4'h1; wait_cyc(6);
      `CHK(modem_irq, 1'b1)
      apb(0, OFS_MODEM_STATUS, 0); `CHK(q[7:0], 8'h11)
      apb(0, OFS_MODEM_STATUS, 0); `CHK(q[7:0], 8'h10)
      wait_cyc(2); `CHK(modem_irq, 1'b0)
      act <= 4'h5; wait_cyc(6); apb(0, OFS_MODEM_STATUS, 0); `CHK(q[7:0], 8'h50)
      act <= 4'h1; wait_cyc(6); apb(0, OFS_MODEM_STATUS, 0); `CHK(q[7:0], 8'h14)
      act <= 4'hB; wait_cyc(6); apb(0, OFS_MODEM_STATUS, 0); `CHK(q[7:0], 8'hBA)
   endtask

   // Loopback mirrors the control outputs
   task automatic t_loop();
      apb(1, OFS_MODEM_CTRL, 32'h1F); wait_cyc(4); apb(0, OFS_MODEM_STATUS, 0);
      `CHK({loopback, q[7:4]}, 5'h1F)
      apb(1, OFS_MODEM_CTRL, 32'h10); wait_cyc(4); apb(0, OFS_MODEM_STATUS, 0);
      `CHK(q[7:4], 4'h0)
      apb(1, OFS_MODEM_CTRL, 32'h00);
   endtask

   // Disable bits gated by the enhanced enable, FIFO read always passes
   task automatic t_disable();
      apb(1, OFS_MODEM_STATUS, 32'h0C); wait_cyc(4);
      `CHK({tx_halt, rx_accept}, 2'b01)
      // Receiver busy at the moment of disabling, so the character completes
      apb(1, OFS_ENH_FEATURE, 32'h10); rxb <= 1'b1;
      apb(1, OFS_MODEM_STATUS, 32'h0C); wait_cyc(4);
      `CHK({tx_halt, rx_accept, tx_xon_allow, rx_xon_detect}, 4'hD)
      rxb <= 1'b0; wait_cyc(3);
      `CHK({rx_accept, rx_xon_detect}, 2'b00)
      apb(1, OFS_MODEM_STATUS, 32'h0F); wait_cyc(4);
      `CHK({tx_xon_allow, rx_xon_detect}, 2'b11)
      @(posedge pclk) rd_req <= 1'b1;
      @(posedge pclk) rd_req <= 1'b0;
      #1 `CHK(rx_fifo_rd, 1'b1)
      // Cleared with the line idle; stays clear for immediate sends
      apb(1, OFS_MODEM_STATUS, 32'h00); wait_cyc(4);
      `CHK({tx_halt, rx_accept}, 2'b01)
   endtask

   // Auto CTS hold, then RTS hysteresis around the trigger levels on table A
   task automatic t_flow();
      apb(1, OFS_ENH_FEATURE, 32'h0000_00D0);
      act <= 4'hA; wait_cyc(6); `CHK(tx_halt, 1'b1)
      act <= 4'hB; wait_cyc(6); `CHK(tx_halt, 1'b0)
      lvl <= 9'h008; wait_cyc(3); `CHK(rts_flow_off, 1'b1)
      lvl <= 9'h005; wait_cyc(3); `CHK(rts_flow_off, 1'b1)
      lvl <= 9'h004; wait_cyc(3); `CHK(rts_flow_off, 1'b0)
   endtask

   // Turn-around delay of two bit times, table D selected
   task automatic t_rs485();
      apb(1, OFS_MODEM_STATUS, 32'h20); apb(1, OFS_FEATURE, 32'hE0);
      wait_cyc(2); `CHK(trigger_table, TABLE_D)
      @(posedge pclk) tx_load <= 1'b1;
      @(posedge pclk) tx_load <= 1'b0;
      wait_cyc(1); `CHK(rs485_dir, 1'b1)
      @(posedge pclk) stop_done <= 1'b1;
      @(posedge pclk) stop_done <= 1'b0;
      repeat (2) begin
         wait_cyc(2); `CHK(rs485_dir, 1'b1)
         @(posedge pclk) tick <= 1'b1;
         @(posedge pclk) tick <= 1'b0;
      end
      wait_cyc(2); `CHK(rs485_dir, 1'b0)
   endtask

   // Reset held two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_modem();
      t_loop();
      t_disable();
      t_flow();
      t_rs485();
      close_out();
   end
endmodule
